// ---- pmcd_regs.sv ----
// Pin source mux, reflectometry config and diagnostic control registers.
// Assumes core-clocked management strobes, one cycle wide per access.
// Event and status sources are levels already on the core clock, so
// they feed the pin mux with no synchroniser.
// Functional notes
// - Pin 1 source from bits 7:4, collision default
// - Pin 0 source from bits 3:0, rx error default
// - Select codes route listed event sources
// - Code 0100 gives energy detect, fast speeds
// - Bit 12 skips channels C and D
// - Bit 11 listens only on transmit channel
// - Bit 10 checks link pulses, resets one
// - Bits 9:7 averaging count, reset 110
// - Averaging code 111 ignored, old value kept
// - Bits 6:4 segment count, reset 101
// - Bits 3:0 cycle time us, reset 010
// - Done bit 5, result byte 15:8
// - Clear bit 4 resets diagnostic results
// - Coding_sublayer_reset bit resets both register sets
// - Coding_sublayer_reset also triggers soft reset
`default_nettype none
module pmcd_regs
  import pmcd_pkg::*;
(
  input wire logic ref_clk_in, // Core clock, 100 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic wr_en_in, // Main space write strobe
  input wire logic rd_en_in, // Main space read strobe
  input wire logic mmd3_wr_en_in, // Coding sublayer space write strobe
  input wire logic mmd3_rd_en_in, // Coding sublayer space read strobe
  input wire logic [15:0] addr_in, // Register address
  input wire logic [15:0] wdata_in, // Write data
  output logic [15:0] rdata_out, // Read data, registered
  input wire logic col_in, // Collision indication
  input wire logic rx_err_in, // Receive error indication
  input wire logic tx_sfd_in, // Transmit SFD timestamp event
  input wire logic rx_sfd_in, // Receive SFD event
  input wire logic wake_on_lan_event_in, // Wake-on-LAN event
  input wire logic energy_det_in, // Energy detect
  input wire logic fast_speed_in, // Link at 1000BASE-T or 100BASE-TX
  input wire logic third_led_output_in, // Third LED state
  input wire logic prbs_err_in, // PRBS error or loss of sync
  input wire logic diag_done_in, // Diagnostic finished pulse
  input wire logic [7:0] diag_result_in, // Result captured with done
  output logic gpio1_out, // General-purpose pin 1
  output logic gpio0_out, // General-purpose pin 0
  output logic refl_upper_channel_bypass_out, // Skip channels C and D
  output logic refl_cross_listen_disable_out, // Listen on tx channel only
  output logic refl_link_pulse_check_out, // Check link pulses in silence
  output logic [2:0] refl_average_count_out, // Averaging code
  output logic [2:0] refl_segment_count_out, // Segment count
  output logic [3:0] refl_cycle_duration_out, // Cycle time in us
  output logic link_diag_clear_out, // One-cycle results clear pulse
  output logic coding_sublayer_reset_out, // One-cycle MMD3/MMD7 reset
  output logic soft_reset_out // One-cycle basic control soft reset
);

  // Stored fields, decoded strobes and register images
  logic [3:0] pin1_sel_q;
  logic [3:0] pin0_sel_q;
  logic [7:0] link_diag_result_q;
  logic link_diag_done_q;
  logic clr_pend_q;
  logic pcs_pend_q;
  logic wr_pin;
  logic wr_refl;
  logic wr_diag;
  logic wr_pcs;
  logic [15:0] rdata_d;
  logic [1:0][3:0] pin_sel;
  logic [1:0] pin_dflt;
  wire logic [1:0] pin_d;
  logic [15:0] pin_img;
  logic [15:0] refl_img;
  logic [15:0] diag_img;
  logic [15:0] pcs_img;
  logic clr_req;
  logic pcs_req;

  // Address decode per space
  assign wr_pin = wr_en_in && (addr_in == PMCD_ADDR_PIN_SEL);
  assign wr_refl = wr_en_in && (addr_in == PMCD_ADDR_REFL_CFG);
  assign wr_diag = wr_en_in && (addr_in == PMCD_ADDR_DIAG_CTRL);
  assign wr_pcs = mmd3_wr_en_in && (addr_in == PMCD_ADDR_PCS_CTRL);

  // Self-clearing requests carried by the data word
  assign clr_req = wr_diag && wdata_in[PMCD_CLR_BIT];
  assign pcs_req = wr_pcs && wdata_in[PMCD_PCS_RST_BIT];

  // Pin select fields
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin1_sel_q <= PMCD_PIN_RST;
      pin0_sel_q <= PMCD_PIN_RST;
    end
    else if (wr_pin)
    begin
      pin1_sel_q <= wdata_in[PMCD_PIN1_LSB +: 4];
      pin0_sel_q <= wdata_in[PMCD_PIN0_LSB +: 4];
    end
  end

  // Per-pin view of the select fields and their default sources
  assign pin_sel = {pin1_sel_q, pin0_sel_q};
  assign pin_dflt = {col_in, rx_err_in};

  // Source mux per pin. A process rather than a function call, so a
  // change on any source re-evaluates it; reserved codes drive low.
  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    logic src_v;
    always_comb
    begin
      src_v = 1'b0;
      case (pin_sel[g])
        PMCD_SRC_DEFAULT: src_v = pin_dflt[g];
        PMCD_SRC_TX_SFD: src_v = tx_sfd_in;
        PMCD_SRC_RX_SFD: src_v = rx_sfd_in;
        PMCD_SRC_WOL: src_v = wake_on_lan_event_in;
        // Energy detect means nothing at the slow speed
        PMCD_SRC_ENERGY: src_v = energy_det_in && fast_speed_in;
        PMCD_SRC_LED3: src_v = third_led_output_in;
        PMCD_SRC_PRBS: src_v = prbs_err_in;
        PMCD_SRC_LOW: src_v = 1'b0;
        PMCD_SRC_HIGH: src_v = 1'b1;
        default: src_v = 1'b0;
      endcase
    end
    assign pin_d[g] = src_v;
  end

  // Pins registered so outputs come from flops; this costs one cycle
  // from source to pin, which event users must allow for
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gpio1_out <= 1'b0;
      gpio0_out <= 1'b0;
    end
    else
    begin
      gpio1_out <= pin_d[1];
      gpio0_out <= pin_d[0];
    end
  end

  // Reflectometry configuration; coding sublayer reset leaves it alone,
  // as these fields sit outside the sublayer register sets
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      refl_upper_channel_bypass_out <= 1'b0;
      refl_cross_listen_disable_out <= 1'b0;
      refl_link_pulse_check_out <= PMCD_NLP_RST;
      refl_average_count_out <= PMCD_AVG_RST;
      refl_segment_count_out <= PMCD_SEG_RST;
      refl_cycle_duration_out <= PMCD_CYC_RST;
    end
    else if (wr_refl)
    begin
      refl_upper_channel_bypass_out <= wdata_in[PMCD_BYP_BIT];
      refl_cross_listen_disable_out <= wdata_in[PMCD_XDIS_BIT];
      refl_link_pulse_check_out <= wdata_in[PMCD_NLP_BIT];
      // Reserved code leaves the previous value in place
      if (wdata_in[PMCD_AVG_LSB +: 3] != PMCD_AVG_RSVD)
      begin
        refl_average_count_out <= wdata_in[PMCD_AVG_LSB +: 3];
      end
      refl_segment_count_out <= wdata_in[PMCD_SEG_LSB +: 3];
      refl_cycle_duration_out <= wdata_in[PMCD_CYC_LSB +: 4];
    end
  end

  // Diagnostic result and done; a finish in the clear cycle wins,
  // so a completed run is never lost to a late clear
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      link_diag_result_q <= 8'h00;
      link_diag_done_q <= 1'b0;
    end
    else if (diag_done_in)
    begin
      link_diag_result_q <= diag_result_in;
      link_diag_done_q <= 1'b1;
    end
    else if (clr_req)
    begin
      link_diag_result_q <= 8'h00;
      link_diag_done_q <= 1'b0;
    end
  end

  // Results clear: pulse to the diagnostic engine, readable for a cycle
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clr_pend_q <= 1'b0;
      link_diag_clear_out <= 1'b0;
    end
    else
    begin
      clr_pend_q <= clr_req;
      link_diag_clear_out <= clr_req;
    end
  end

  // Sublayer reset chain; the soft reset trails by a cycle so the
  // register sets are back at defaults before the core restarts
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pcs_pend_q <= 1'b0;
      coding_sublayer_reset_out <= 1'b0;
      soft_reset_out <= 1'b0;
    end
    else
    begin
      pcs_pend_q <= pcs_req;
      coding_sublayer_reset_out <= pcs_req;
      soft_reset_out <= coding_sublayer_reset_out;
    end
  end

  // Pin select image; upper byte reserved, reads zero
  always_comb
  begin
    pin_img = 16'h0000;
    pin_img[PMCD_PIN1_LSB +: 4] = pin1_sel_q;
    pin_img[PMCD_PIN0_LSB +: 4] = pin0_sel_q;
  end

  // Reflectometry image; code 111 never lands, so never reads back
  always_comb
  begin
    refl_img = 16'h0000;
    refl_img[PMCD_BYP_BIT] = refl_upper_channel_bypass_out;
    refl_img[PMCD_XDIS_BIT] = refl_cross_listen_disable_out;
    refl_img[PMCD_NLP_BIT] = refl_link_pulse_check_out;
    refl_img[PMCD_AVG_LSB +: 3] = refl_average_count_out;
    refl_img[PMCD_SEG_LSB +: 3] = refl_segment_count_out;
    refl_img[PMCD_CYC_LSB +: 4] = refl_cycle_duration_out;
  end

  // Diagnostic image; the clear bit shows 1 for one cycle only
  always_comb
  begin
    diag_img = 16'h0000;
    diag_img[PMCD_RES_LSB +: 8] = link_diag_result_q;
    diag_img[PMCD_DONE_BIT] = link_diag_done_q;
    diag_img[PMCD_CLR_BIT] = clr_pend_q;
  end

  // Sublayer control image; only the self-clearing reset bit is live
  always_comb
  begin
    pcs_img = 16'h0000;
    pcs_img[PMCD_PCS_RST_BIT] = pcs_pend_q;
  end

  // Read mux per space; unmapped addresses read zero. The main space
  // wins if both strobes come together, which software never does.
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_en_in)
    begin
      case (addr_in)
        PMCD_ADDR_PIN_SEL: rdata_d = pin_img;
        PMCD_ADDR_REFL_CFG: rdata_d = refl_img;
        PMCD_ADDR_DIAG_CTRL: rdata_d = diag_img;
        default: rdata_d = 16'h0000;
      endcase
    end
    else if (mmd3_rd_en_in && (addr_in == PMCD_ADDR_PCS_CTRL))
    begin
      rdata_d = pcs_img;
    end
  end

  // Read data held until the next read
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 16'h0000;
    end
    else if (rd_en_in || mmd3_rd_en_in)
    begin
      rdata_out <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ---- pmcd_pkg.sv ----
// Package for the pin mux and cable diagnostic register bank.
// Assumes a 16-bit management register port driven by the device core.
`default_nettype none
package pmcd_pkg;
  // Register addresses: the main bank and the coding sublayer space
  localparam logic [15:0] PMCD_ADDR_PIN_SEL = 16'h0172;
  localparam logic [15:0] PMCD_ADDR_REFL_CFG = 16'h0180;
  localparam logic [15:0] PMCD_ADDR_DIAG_CTRL = 16'h01a7;
  localparam logic [15:0] PMCD_ADDR_PCS_CTRL = 16'h0000;
  // Pin select field layout
  localparam int PMCD_PIN1_LSB = 4;
  localparam int PMCD_PIN0_LSB = 0;
  localparam logic [3:0] PMCD_PIN_RST = 4'h0;
  // Pin source codes
  localparam logic [3:0] PMCD_SRC_DEFAULT = 4'h0;
  localparam logic [3:0] PMCD_SRC_TX_SFD = 4'h1;
  localparam logic [3:0] PMCD_SRC_RX_SFD = 4'h2;
  localparam logic [3:0] PMCD_SRC_WOL = 4'h3;
  localparam logic [3:0] PMCD_SRC_ENERGY = 4'h4;
  localparam logic [3:0] PMCD_SRC_LED3 = 4'h6;
  localparam logic [3:0] PMCD_SRC_PRBS = 4'h7;
  localparam logic [3:0] PMCD_SRC_LOW = 4'h8;
  localparam logic [3:0] PMCD_SRC_HIGH = 4'h9;
  // Reflectometry configuration layout
  localparam int PMCD_BYP_BIT = 12;
  localparam int PMCD_XDIS_BIT = 11;
  localparam int PMCD_NLP_BIT = 10;
  localparam int PMCD_AVG_LSB = 7;
  localparam int PMCD_SEG_LSB = 4;
  localparam int PMCD_CYC_LSB = 0;
  localparam logic [2:0] PMCD_AVG_RSVD = 3'h7;
  localparam logic PMCD_NLP_RST = 1'b1;
  localparam logic [2:0] PMCD_AVG_RST = 3'h6;
  localparam logic [2:0] PMCD_SEG_RST = 3'h5;
  localparam logic [3:0] PMCD_CYC_RST = 4'h2;
  // Cable diagnostic control layout
  localparam int PMCD_RES_LSB = 8;
  localparam int PMCD_DONE_BIT = 5;
  localparam int PMCD_CLR_BIT = 4;
  // Coding sublayer control layout
  localparam int PMCD_PCS_RST_BIT = 15;
endpackage
`default_nettype wire

// ---- pmcd_regs_properties.sv ----
// Checker for the pin mux and diagnostic register bank.
// Bound to pmcd_regs; watches its ports only.
`default_nettype none
module pmcd_regs_chk
  import pmcd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic mmd3_wr_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic refl_upper_channel_bypass_out,
  input wire logic refl_cross_listen_disable_out,
  input wire logic refl_link_pulse_check_out,
  input wire logic [2:0] refl_average_count_out,
  input wire logic [2:0] refl_segment_count_out,
  input wire logic [3:0] refl_cycle_duration_out,
  input wire logic link_diag_clear_out,
  input wire logic coding_sublayer_reset_out,
  input wire logic soft_reset_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Decoded writes; config gathered in its register layout
  wire logic rw = wr_en_in && addr_in == PMCD_ADDR_REFL_CFG;
  wire logic cw = wr_en_in && addr_in == PMCD_ADDR_DIAG_CTRL && wdata_in[4];
  wire logic pw = mmd3_wr_en_in && addr_in == PMCD_ADDR_PCS_CTRL;
  wire logic rsv = wdata_in[9:7] == PMCD_AVG_RSVD;
  wire logic cs = coding_sublayer_reset_out;
  wire logic [12:0] cfg = {refl_upper_channel_bypass_out,
    refl_cross_listen_disable_out, refl_link_pulse_check_out,
    refl_average_count_out, refl_segment_count_out, refl_cycle_duration_out};
  property p_pcs; pw && wdata_in[15] |=> cs; endproperty
  a_pcs: assert property (p_pcs) else $error("no coding_sublayer_reset");
  property p_soft; cs |=> soft_reset_out; endproperty
  a_soft: assert property (p_soft) else $error("no soft reset");
  property p_clr;
    cw |=> link_diag_clear_out ##1 (!link_diag_clear_out || $past(cw));
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_byp; rw |=> cfg[12] == $past(wdata_in[12]); endproperty
  a_byp: assert property (p_byp) else $error("bad bypass");
  property p_xd; rw |=> cfg[11] == $past(wdata_in[11]); endproperty
  a_xd: assert property (p_xd) else $error("bad cross");
  property p_nlp; rw |=> cfg[10] == $past(wdata_in[10]); endproperty
  a_nlp: assert property (p_nlp) else $error("bad pulse chk");
  property p_avg; rw && !rsv |=> cfg[9:7] == $past(wdata_in[9:7]); endproperty
  a_avg: assert property (p_avg) else $error("bad average");
  property p_rsv; rw && rsv |=> $stable(cfg[9:7]); endproperty
  a_rsv: assert property (p_rsv) else $error("avg 7 taken");
  property p_seg; rw |=> cfg[6:0] == $past(wdata_in[6:0]); endproperty
  a_seg: assert property (p_seg) else $error("bad seg/cyc");
  // Main scenarios reached
  c_pcs: cover property (pw && wdata_in[15]);
  c_clr: cover property (cw);
  c_rsv: cover property (rw && rsv);
endmodule
bind pmcd_regs pmcd_regs_chk u_chk (.*);
`default_nettype wire

// ---- tb_pmcd_regs.sv ----
// Self-checking bench for the pin mux and diagnostic register bank.
// Assumes pmcd_pkg, pmcd_regs and its checker compiled first.
`default_nettype none
module tb_pmcd_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import pmcd_pkg::*;
  logic ref_clk_in, rst_in, wr_en_in, rd_en_in, mmd3_wr_en_in, mmd3_rd_en_in;
  logic [15:0] addr_in, wdata_in, rdata_out, refl_o;
  logic col_in, rx_err_in, tx_sfd_in, rx_sfd_in, wake_on_lan_event_in;
  logic energy_det_in, fast_speed_in, third_led_output_in, prbs_err_in;
  logic diag_done_in, gpio1_out, gpio0_out, link_diag_clear_out;
  logic refl_upper_channel_bypass_out, refl_cross_listen_disable_out;
  logic refl_link_pulse_check_out, coding_sublayer_reset_out, soft_reset_out;
  logic [2:0] refl_average_count_out, refl_segment_count_out;
  logic [3:0] refl_cycle_duration_out;
  logic [7:0] diag_result_in, src, s;
  int n_mismatch = 0;
  int check_count = 0;
  pmcd_regs u_dut (.*);
  // Sources indexed by select code; slot 5 (reserved) holds rx error
  assign {prbs_err_in, third_led_output_in, rx_err_in, energy_det_in,
    wake_on_lan_event_in, rx_sfd_in, tx_sfd_in, col_in} = src;
  assign refl_o = {3'h0, refl_upper_channel_bypass_out,
    refl_cross_listen_disable_out, refl_link_pulse_check_out,
    refl_average_count_out, refl_segment_count_out, refl_cycle_duration_out};
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // Strobe held for exactly the one taking edge
  task automatic wr(input logic [15:0] a, v, input logic m);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_en_in <= !m;
    mmd3_wr_en_in <= m;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    mmd3_wr_en_in <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic m,
                     input logic [15:0] e, input string n);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_en_in <= !m;
    mmd3_rd_en_in <= m;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    mmd3_rd_en_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk(n, e, rdata_out);
  endtask
  // Energy detect only counts at the fast speeds
  function automatic logic pexp(input logic [3:0] c, input logic p, f);
    return c == 4'h8 ? 1'b0 : c == 4'h9 ? 1'b1 : c == 4'h4 ? s[4] & f :
      (c == 4'h0 && !p) ? s[5] : s[c];
  endfunction
  task automatic t_pins();
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 10; k++)
      begin
        if (k == 5)
          continue;
        s = 8'ha5 ^ {8{p[0]}};
        @(posedge ref_clk_in);
        src <= s;
        fast_speed_in <= p[1];
        wr(PMCD_ADDR_PIN_SEL, {8'h00, k[3:0], k[3:0]}, 1'b0);
        @(posedge ref_clk_in);
        #1;
        chk("gpio1", 16'(pexp(k[3:0], 1'b1, p[1])), 16'(gpio1_out));
        chk("gpio0", 16'(pexp(k[3:0], 1'b0, p[1])), 16'(gpio0_out));
      end
    rdc(PMCD_ADDR_PIN_SEL, 1'b0, 16'h0099, "pin_sel");
  endtask
  // Reserved average code keeps the old count, other fields still land
  task automatic t_refl();
    wr(PMCD_ADDR_REFL_CFG, 16'h11a9, 1'b0);
    chk("refl_o", 16'h11a9, refl_o);
    wr(PMCD_ADDR_REFL_CFG, 16'hebff, 1'b0);
    rdc(PMCD_ADDR_REFL_CFG, 1'b0, 16'h09ff, "refl");
    wr(PMCD_ADDR_REFL_CFG, 16'h0780, 1'b0);
    chk("refl_o", 16'h0580, refl_o);
  endtask
  task automatic t_diag();
    @(posedge ref_clk_in);
    diag_done_in <= 1'b1;
    diag_result_in <= 8'hc3;
    @(posedge ref_clk_in);
    diag_done_in <= 1'b0;
    diag_result_in <= 8'h3c;
    rdc(PMCD_ADDR_DIAG_CTRL, 1'b0, 16'hc320, "diag");
    wr(PMCD_ADDR_DIAG_CTRL, 16'hffff, 1'b0);
    chk("clear", 16'h0001, 16'(link_diag_clear_out));
    rdc(PMCD_ADDR_DIAG_CTRL, 1'b0, 16'h0000, "diag_clr");
  endtask
  // Main-space address zero must not reach the sublayer reset
  task automatic t_pcs();
    wr(PMCD_ADDR_PCS_CTRL, 16'h8000, 1'b0);
    chk("main0", 16'h0, 16'({coding_sublayer_reset_out, soft_reset_out}));
    wr(PMCD_ADDR_PCS_CTRL, 16'hffff, 1'b1);
    chk("pcs", 16'h2, 16'({coding_sublayer_reset_out, soft_reset_out}));
    @(posedge ref_clk_in);
    #1;
    chk("soft", 16'h1, 16'({coding_sublayer_reset_out, soft_reset_out}));
    rdc(PMCD_ADDR_PCS_CTRL, 1'b1, 16'h0000, "pcs_rd");
    rdc(16'h0123, 1'b0, 16'h0000, "unmapped");
  endtask
  initial
  begin
    rst_in = 1'b1;
    {wr_en_in, rd_en_in, mmd3_wr_en_in, mmd3_rd_en_in, diag_done_in} = '0;
    {addr_in, wdata_in, src, diag_result_in, fast_speed_in} = '0;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    chk("refl_rst", 16'h0752, refl_o);
    rdc(PMCD_ADDR_REFL_CFG, 1'b0, 16'h0752, "refl_rd");
    t_pins();
    t_refl();
    t_diag();
    t_pcs();
    report_and_stop();
  end
  // Run needs about 190 cycles
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
